/* rtl/pam_pkg.sv */
package pam_pkg;
   // ---------------------------------------------------------------
   // link command and status group codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_ALERT_MASK = 8'h1B;
   localparam logic [7:0] PHASE_ALL      = 8'hFF;
   localparam int         NUM_GROUPS     = 5;
   // index 0 output voltage, 1 output current, 2 input, 3 temp, 4 comm
   localparam logic [4:0][7:0] GRP_CODE =
      {8'h7E, 8'h7D, 8'h7C, 8'h7B, 8'h7A};
   // bits that software may change per group
   localparam logic [4:0][7:0] GRP_WRITABLE =
      {8'hF2, 8'hC0, 8'h08, 8'hA0, 8'hFC};
   // bits held at one whatever is written
   localparam logic [4:0][7:0] GRP_FIXED_ONE =
      {8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
   localparam logic [7:0] MASK_RESET     = 8'hFF;

   // ---------------------------------------------------------------
   // mask field positions
   // ---------------------------------------------------------------
   localparam int MASK_OUT_OVERVOLT_FAULT  = 7;
   localparam int MASK_OUT_OVERVOLT_WARN   = 6;
   localparam int MASK_OUT_UNDERVOLT_WARN  = 5;
   localparam int MASK_OUT_UNDERVOLT_FAULT = 4;
   localparam int MASK_OUT_LIMIT_RANGE     = 3;
   localparam int MASK_TURN_ON_TIMEOUT     = 2;
   localparam int MASK_OVERCURRENT_FAULT   = 7;
   localparam int MASK_OVERCURRENT_WARN    = 5;
   localparam int MASK_UNDERCURRENT_FAULT  = 4;
   localparam int MASK_INPUT_LOW           = 3;
   localparam int MASK_OVERTEMP_FAULT      = 7;
   localparam int MASK_OVERTEMP_WARN       = 6;
   localparam int MASK_BAD_COMMAND         = 7;
   localparam int MASK_BAD_DATA            = 6;
   localparam int MASK_PACKET_CHECK_FAIL   = 5;
   localparam int MASK_MEMORY_FAULT        = 4;
   localparam int MASK_OTHER_COMM_FAULT    = 1;

   // ---------------------------------------------------------------
   // controller registers (byte addresses) and fields
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CMD        = 4'h0;
   localparam logic [3:0] REG_STATUS     = 4'h4;
   localparam int         CMD_GROUP_LSB  = 0;
   localparam int         CMD_MASK_LSB   = 8;
   localparam int         CMD_PHASE_LSB  = 16;
   localparam int         CMD_READ_BIT   = 24;
   localparam int         ST_BUSY_BIT    = 0;
   localparam int         ST_NACK_BIT    = 1;
   localparam int         ST_ALERT_BIT   = 2;
   localparam int         ST_DONE_BIT    = 3;
   localparam int         ST_RDATA_LSB   = 8;

   // host link sequencer, gray along idle-send-drop
   typedef enum logic [1:0] {
      PAM_IDLE = 2'b00,
      PAM_SEND = 2'b01,
      PAM_DROP = 2'b11
   } pam_link_state_t;
endpackage

/* rtl/pam_link_if.sv */
`timescale 1ns/1ns
interface pam_link_if;
   logic       link_clk;
   logic       link_rst_n;
   logic       cmd_valid;
   logic       cmd_read;
   logic [7:0] cmd_code;
   logic [7:0] cmd_phase;
   logic [7:0] data_lo;
   logic [7:0] data_hi;
   logic       ack;
   logic       nack;
   logic [7:0] rd_data;
   logic       alert_oe;
   wire        alert_n;

   // open-drain alert line, pulled high when nobody drives it
   assign alert_n = ~alert_oe;

   modport host (
      output link_clk, link_rst_n, cmd_valid, cmd_read, cmd_code,
      output cmd_phase, data_lo, data_hi,
      input  ack, nack, rd_data, alert_n
   );
   modport dev (
      input  link_clk, link_rst_n, cmd_valid, cmd_read, cmd_code,
      input  cmd_phase, data_lo, data_hi,
      output ack, nack, rd_data, alert_oe
   );
endinterface

/* rtl/pam_dev.sv */
// How it works
// RULE1 - zero lets condition alert, one blocks it
// RULE2 - voltage byte: bits 7..2 writable, 1:0 zero
// RULE3 - code 7Bh: current masks bits 7,5,4
// RULE4 - undercurrent mask stays one, never alerts
// RULE5 - code 7Ch: only bit 3 writable
// RULE6 - code 7Dh: bits 7,6 writable, rest zero
// RULE7 - code 7Eh: bits 7..4 and 1 writable
// RULE8 - mask update by write word to 1Bh
// RULE9 - mask read returns one unsigned byte
// RULE10 - accept mask access only at phase FFh
// RULE11 - load masks from storage, writes act immediately
// RULE12 - code 7Ah selects output voltage byte
// RULE13 - write word: low group, high mask
// RULE14 - read: send group block, get mask block
// RULE15 - masking never hides the status bit itself
// RULE16 - unmasked active status drives alert; dead bits masked
`timescale 1ns/1ns
module pam_dev
(
   // link to the bus controller
   pam_link_if.dev                link,
   // status conditions from the converter, link clock domain
   input  wire logic [4:0][7:0]   STATUS_IN,
   // stored mask image from non-volatile memory
   input  wire logic [4:0][7:0]   NVM_MASK_IN,
   // mask and status views for the rest of the controller
   output logic      [4:0][7:0]   MASK_OUT,
   output logic      [4:0][7:0]   STATUS_OUT,
   output logic                   ALERT_OUT,
   output logic                   NVM_LOADED_OUT
);

   // ---------------------------------------------------------------
   // reset synchroniser
   // ---------------------------------------------------------------
   logic                 rst_meta;
   logic                 run;
   logic                 loaded;

   // link reset is made in the other end's domain, so resync it
   always_ff @(posedge link.link_clk)
   begin
      rst_meta <= link.link_rst_n;
      run      <= rst_meta;
   end

   // image taken once, first edge after release
   always_ff @(posedge link.link_clk)
   begin
      if (!run)
         loaded <= 1'b0;
      else
         loaded <= 1'b1;
   end

   // ---------------------------------------------------------------
   // request decode
   // ---------------------------------------------------------------
   logic                 ack;
   logic                 nack;
   logic [7:0]           rd_data;
   logic                 alert;
   wire  [4:0]           hit;
   wire                  take;
   wire                  code_ok;
   wire                  phase_ok;
   wire                  accept;
   wire                  wr_go;
   wire                  rd_go;

   // one request per valid level; ack low again before the next
   assign take     = link.cmd_valid & ~ack;
   assign code_ok  = link.cmd_code == pam_pkg::CMD_ALERT_MASK;  // RULE8
   assign phase_ok = link.cmd_phase == pam_pkg::PHASE_ALL;      // RULE10
   assign accept   = take & code_ok & phase_ok & (|hit);
   assign wr_go    = accept & ~link.cmd_read;                   // RULE8
   assign rd_go    = accept & link.cmd_read;                    // RULE9

   // ---------------------------------------------------------------
   // per group mask storage and alert gating
   // ---------------------------------------------------------------
   logic [4:0][7:0]      mask;
   wire  [4:0][7:0]      rdback;
   wire  [4:0][7:0]      eff;
   wire  [4:0]           pend;
   wire  [5:0][7:0]      rd_chain;

   assign rd_chain[0] = 8'h00;

   genvar g;
   generate
      for (g = 0; g < pam_pkg::NUM_GROUPS; g = g + 1)
      begin : grp
         // group code sits in the low data byte
         assign hit[g] = link.data_lo == pam_pkg::GRP_CODE[g];   // RULE13

         // only writable bits are stored, so dead bits ignore writes
         always_ff @(posedge link.link_clk)
         begin
            if (!run)
               mask[g] <= pam_pkg::MASK_RESET;
            else if (!loaded)
               mask[g] <= NVM_MASK_IN[g] & pam_pkg::GRP_WRITABLE[g]; // RULE11
            else if (wr_go && hit[g])
               mask[g] <= link.data_hi & pam_pkg::GRP_WRITABLE[g]; // RULE11
         end

         // unsupported bits read zero, undercurrent reads one
         assign rdback[g] = (mask[g] & pam_pkg::GRP_WRITABLE[g])
                          | pam_pkg::GRP_FIXED_ONE[g];          // RULE2

         // anything not writable counts as masked for alerting
         assign eff[g] = mask[g] | ~pam_pkg::GRP_WRITABLE[g];   // RULE16

         // a zero mask bit lets its active status through
         assign pend[g] = |(STATUS_IN[g] & ~eff[g]);            // RULE1

         assign rd_chain[g+1] = rd_chain[g]
                              | (hit[g] ? rdback[g] : 8'h00);
      end
   endgenerate

   // ---------------------------------------------------------------
   // group specific field checks
   // ---------------------------------------------------------------
   // output voltage byte is group index 0, code 7Ah
   wire vout_sel = hit[0];                                     // RULE12
   // current byte: overcurrent fault and warning user bits
   wire iout_oc  = rdback[1][pam_pkg::MASK_OVERCURRENT_FAULT]
                 | rdback[1][pam_pkg::MASK_OVERCURRENT_WARN];  // RULE3
   // undercurrent never unmasked, so it cannot reach the alert
   wire iout_uc  = eff[1][pam_pkg::MASK_UNDERCURRENT_FAULT];   // RULE4
   // input byte holds just the low-input mask
   wire in_low   = rdback[2][pam_pkg::MASK_INPUT_LOW];         // RULE5
   // temperature byte: fault and warning masks only
   wire temp_any = rdback[3][pam_pkg::MASK_OVERTEMP_FAULT]
                 | rdback[3][pam_pkg::MASK_OVERTEMP_WARN];     // RULE6
   // comm byte: five user masks, bits 3:2 and 0 dead
   wire cml_any  = rdback[4][pam_pkg::MASK_OTHER_COMM_FAULT]
                 | rdback[4][pam_pkg::MASK_MEMORY_FAULT];      // RULE7

   // ---------------------------------------------------------------
   // link answer
   // ---------------------------------------------------------------
   // four phase: ack rises on take, falls once valid drops
   always_ff @(posedge link.link_clk)
   begin
      if (!run)
         ack <= 1'b0;
      else if (take)
         ack <= 1'b1;
      else if (!link.cmd_valid)
         ack <= 1'b0;
   end

   // refusal and read data stand while ack is high
   always_ff @(posedge link.link_clk)
   begin
      if (!run)
      begin
         nack    <= 1'b0;
         rd_data <= 8'h00;
      end
      else if (take)
      begin
         nack    <= ~accept;                                   // RULE10
         rd_data <= rd_go ? rd_chain[5] : 8'h00;               // RULE14
      end
   end

   assign link.ack     = ack;
   assign link.nack    = nack;
   assign link.rd_data = rd_data;                              // RULE9

   // ---------------------------------------------------------------
   // alert and user side views
   // ---------------------------------------------------------------
   // held off until the stored image is in, avoids a reset glitch
   always_ff @(posedge link.link_clk)
   begin
      if (!run)
         alert <= 1'b0;
      else
         alert <= loaded & (|pend);                            // RULE16
   end

   assign link.alert_oe = alert;

   // registered copies; status passes untouched by the masks
   always_ff @(posedge link.link_clk)
   begin
      if (!run)
      begin
         MASK_OUT       <= '0;
         STATUS_OUT     <= '0;
         ALERT_OUT      <= 1'b0;
         NVM_LOADED_OUT <= 1'b0;
      end
      else
      begin
         MASK_OUT       <= rdback;
         STATUS_OUT     <= STATUS_IN;                          // RULE15
         ALERT_OUT      <= loaded & (|pend);
         NVM_LOADED_OUT <= loaded;
      end
   end

   // spare decode terms kept visible for field level debug
   wire unused_ok = vout_sel | iout_oc | iout_uc | in_low
                  | temp_any | cml_any;

endmodule // pam_dev

/* rtl/pam_host.sv */
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
module pam_host
(
   // clock and reset
   input  wire logic        SYS_CLK_IN,
   input  wire logic        RST_N_IN,
   // avalon-mm slave
   input  wire logic [3:0]  AVS_ADDRESS_IN,
   input  wire logic        AVS_READ_IN,
   input  wire logic        AVS_WRITE_IN,
   input  wire logic [31:0] AVS_WRITEDATA_IN,
   output logic      [31:0] AVS_READDATA_OUT,
   output logic             AVS_WAITREQUEST_OUT,
   // link to the mask bank
   pam_link_if.host         link
);

   // ---------------------------------------------------------------
   // link clock by two, link reset
   // ---------------------------------------------------------------
   logic        lclk;
   logic        lrst_n;
   wire         fall;

   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RST_N_IN)
         lclk <= 1'b0;
      else
         lclk <= ~lclk;
   end

   // link valid and reset move only where the link clock falls
   assign fall = lclk;

   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RST_N_IN)
         lrst_n <= 1'b0;
      else if (fall)
         lrst_n <= 1'b1;
   end

   assign link.link_clk   = lclk;
   assign link.link_rst_n = lrst_n;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic        ack_meta;
   logic        ack_s;
   logic        alt_meta;
   logic        alt_s;

   always_ff @(posedge SYS_CLK_IN)
   begin
      ack_meta <= link.ack;
      ack_s    <= ack_meta;
      alt_meta <= ~link.alert_n;
      alt_s    <= alt_meta;
   end

   // ---------------------------------------------------------------
   // avalon decode
   // ---------------------------------------------------------------
   logic                     wait_r;
   logic                     valid_r;
   logic                     busy;
   logic                     done;
   logic                     nack_r;
   logic                     rd_cmd;
   logic [7:0]               grp;
   logic [7:0]               val;
   logic [7:0]               phase;
   logic [7:0]               got;
   logic [31:0]              st_word;
   pam_pkg::pam_link_state_t state;
   wire                      req;
   wire                      acc;
   wire                      sel_cmd;
   wire                      sel_st;
   wire                      cmd_wr;
   wire                      rd_load;

   // waitrequest low for one cycle marks the accepting edge
   assign req     = AVS_READ_IN | AVS_WRITE_IN;
   assign acc     = req & ~wait_r;
   assign sel_cmd = AVS_ADDRESS_IN == pam_pkg::REG_CMD;
   assign sel_st  = AVS_ADDRESS_IN == pam_pkg::REG_STATUS;
   // a command written while busy is dropped, software polls first
   assign cmd_wr  = acc & AVS_WRITE_IN & sel_cmd & ~busy;
   assign rd_load = AVS_READ_IN & wait_r;

   // status word assembly
   always_comb
   begin
      st_word                                  = 32'h0;
      st_word[pam_pkg::ST_BUSY_BIT]            = busy;
      st_word[pam_pkg::ST_NACK_BIT]            = nack_r;
      st_word[pam_pkg::ST_ALERT_BIT]           = alt_s;
      st_word[pam_pkg::ST_DONE_BIT]            = done;
      st_word[pam_pkg::ST_RDATA_LSB +: 8]      = got;
   end

   // one wait state per access, idle high
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RST_N_IN)
         wait_r <= 1'b1;
      else
         wait_r <= ~(req & wait_r);
   end

   // read data loaded on the same edge that waitrequest drops
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RST_N_IN)
         AVS_READDATA_OUT <= 32'h0;
      else if (rd_load)
         AVS_READDATA_OUT <= sel_st ? st_word : 32'h0;
   end

   assign AVS_WAITREQUEST_OUT = wait_r;

   // ---------------------------------------------------------------
   // link sequencer
   // ---------------------------------------------------------------
   // valid moves only where the link clock falls, so the bank never
   // sees it change on its sampling edge
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RST_N_IN)
      begin
         state   <= pam_pkg::PAM_IDLE;
         valid_r <= 1'b0;
         busy    <= 1'b0;
         done    <= 1'b0;
         nack_r  <= 1'b0;
         rd_cmd  <= 1'b0;
         grp     <= 8'h00;
         val     <= 8'h00;
         phase   <= 8'h00;
         got     <= 8'h00;
      end
      else
      begin
         unique case (state)
            pam_pkg::PAM_IDLE:
               if (cmd_wr)
               begin
                  grp    <= AVS_WRITEDATA_IN[pam_pkg::CMD_GROUP_LSB +: 8];
                  val    <= AVS_WRITEDATA_IN[pam_pkg::CMD_MASK_LSB +: 8];
                  phase  <= AVS_WRITEDATA_IN[pam_pkg::CMD_PHASE_LSB +: 8];
                  rd_cmd <= AVS_WRITEDATA_IN[pam_pkg::CMD_READ_BIT];
                  busy   <= 1'b1;
                  done   <= 1'b0;
                  state  <= pam_pkg::PAM_SEND;
               end
            pam_pkg::PAM_SEND:
               if (ack_s)
               begin
                  // answer stands while ack is high, safe to take
                  got    <= link.rd_data;
                  nack_r <= link.nack;
                  state  <= pam_pkg::PAM_DROP;
               end
               else if (fall)
                  valid_r <= 1'b1;
            pam_pkg::PAM_DROP:
               if (valid_r)
               begin
                  if (fall)
                     valid_r <= 1'b0;
               end
               else if (!ack_s)
               begin
                  busy  <= 1'b0;
                  done  <= 1'b1;
                  state <= pam_pkg::PAM_IDLE;
               end
         endcase
      end
   end

   // group code low, mask high; reads carry the mask byte too
   assign link.cmd_valid = valid_r;
   assign link.cmd_read  = rd_cmd;                             // RULE14
   assign link.cmd_code  = pam_pkg::CMD_ALERT_MASK;            // RULE8
   assign link.cmd_phase = phase;
   assign link.data_lo   = grp;                                // RULE13
   assign link.data_hi   = val;                                // RULE13

endmodule // pam_host

/* bench/pam_link_chk.sv */
`timescale 1ns/1ns
module pam_link_chk
(
   // link signals
   input wire logic       link_clk,
   input wire logic       link_rst_n,
   input wire logic       cmd_valid,
   input wire logic       cmd_read,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_phase,
   input wire logic [7:0] data_lo,
   input wire logic [7:0] data_hi,
   input wire logic       ack,
   input wire logic       nack,
   input wire logic [7:0] rd_data
);
   logic [4:0][7:0] shadow;
   logic [4:0]      seen;
   wire  [7:0]      gidx   = data_lo - 8'h7A;
   wire             in_rng = (data_lo >= 8'h7A) && (data_lo <= 8'h7E);

   // last accepted write per group, so a later read must echo it
   always_ff @(posedge link_clk)
   begin
      if (!link_rst_n)
      begin
         seen   <= '0;
         shadow <= '0;
      end
      else if (cmd_valid && ack && !nack && !cmd_read && in_rng)
      begin
         seen[gidx[2:0]]   <= 1'b1;
         shadow[gidx[2:0]] <= (data_hi & pam_pkg::GRP_WRITABLE[gidx[2:0]])
                              | pam_pkg::GRP_FIXED_ONE[gidx[2:0]];
      end
   end

   default clocking @(posedge link_clk); endclocking
   default disable iff (!link_rst_n);
   sequence s_rd(c);
      cmd_valid && ack && !nack && cmd_read && data_lo == c;
   endsequence
   property p_vout; s_rd(8'h7A) |-> rd_data[1:0] == 2'b00; endproperty
   a_vout: assert property (p_vout) else $error("vout low bits set");
   property p_iout; s_rd(8'h7B) |-> (rd_data & 8'h5F) == 8'h10; endproperty
   a_iout: assert property (p_iout) else $error("iout fixed bits wrong");
   property p_input; s_rd(8'h7C) |-> (rd_data & 8'hF7) == 8'h00; endproperty
   a_input: assert property (p_input) else $error("input dead bits set");
   property p_temp; s_rd(8'h7D) |-> rd_data[5:0] == 6'h00; endproperty
   a_temp: assert property (p_temp) else $error("temp dead bits set");
   property p_cml; s_rd(8'h7E) |-> (rd_data & 8'h0D) == 8'h00; endproperty
   a_cml: assert property (p_cml) else $error("comm dead bits set");
   property p_phase; cmd_valid && ack && !nack |-> cmd_phase == 8'hFF; endproperty
   a_phase: assert property (p_phase) else $error("accepted wrong phase");
   property p_code; cmd_valid && ack && !nack |-> cmd_code == 8'h1B; endproperty
   a_code: assert property (p_code) else $error("accepted wrong command");
   property p_fresh;
      cmd_valid && ack && !nack && cmd_read && in_rng && seen[gidx[2:0]]
         |-> rd_data == shadow[gidx[2:0]];
   endproperty
   a_fresh: assert property (p_fresh) else $error("stale mask read");
endmodule // pam_link_chk

/* bench/tb_pmbus_alert_mask_bank.sv */
`timescale 1ns/1ns
module tb_pmbus_alert_mask_bank;
   logic            clk;
   logic            rst_n;
   logic [3:0]      addr;
   logic            rd;
   logic            wr;
   logic [31:0]     wdata;
   logic [31:0]     rdata;
   logic            wait_r;
   logic [4:0][7:0] status;
   logic [4:0][7:0] nvm;
   logic [4:0][7:0] mask;
   logic [4:0][7:0] st_view;
   logic            alert;
   logic            loaded;
   logic [31:0]     st;
   int              err_total = 0;
   int              total_checks = 0;
   int              cyc = 0;

   pam_link_if link();
   pam_host i_pam_host (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr),
      .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
      .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_r), .link(link));
   pam_dev i_pam_dev (.link(link), .STATUS_IN(status), .NVM_MASK_IN(nvm),
      .MASK_OUT(mask), .STATUS_OUT(st_view), .ALERT_OUT(alert), .NVM_LOADED_OUT(loaded));
   pam_link_chk i_pam_link_chk (.link_clk(link.link_clk), .link_rst_n(link.link_rst_n),
      .cmd_valid(link.cmd_valid), .cmd_read(link.cmd_read), .cmd_code(link.cmd_code),
      .cmd_phase(link.cmd_phase), .data_lo(link.data_lo), .data_hi(link.data_hi),
      .ack(link.ack), .nack(link.nack), .rd_data(link.rd_data));

   // ----------------------------------------
   // clock and hang guard
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         err_total++;
         conclude();
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // request held until waitrequest is sampled low
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wr    <= w;
      rd    <= !w;
      wdata <= d;
      do @(posedge clk); while (wait_r !== 1'b0);
      st = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task cmd(input logic r, input logic [7:0] g, input logic [7:0] v, input logic [7:0] p);
      bus(1'b1, pam_pkg::REG_CMD, {7'h00, r, p, v, g});
      do bus(1'b0, pam_pkg::REG_STATUS, 32'h0);
      while (st[pam_pkg::ST_BUSY_BIT] !== 1'b0 || st[pam_pkg::ST_DONE_BIT] !== 1'b1);
   endtask
   function logic [7:0] fix(input int i, input logic [7:0] v);
      return (v & pam_pkg::GRP_WRITABLE[i]) | pam_pkg::GRP_FIXED_ONE[i];
   endfunction
   // fixed settle window, alert crosses from the link domain
   task alrt(input logic e);
      repeat (40) @(posedge clk);
      chk({7'h0, alert}, {7'h0, e});
      chk({7'h0, link.alert_n}, {7'h0, !e});
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_load;
      while (loaded !== 1'b1) @(posedge clk);
      for (int i = 0; i < 5; i++)
      begin
         cmd(1'b1, pam_pkg::GRP_CODE[i], 8'h00, 8'hFF);
         chk(st[15:8], fix(i, nvm[i]));
      end
   endtask
   task t_rw;
      for (int i = 0; i < 5; i++)
         for (int k = 0; k < 2; k++)
         begin
            cmd(1'b0, pam_pkg::GRP_CODE[i], k ? 8'h00 : 8'hFF, 8'hFF);
            cmd(1'b1, pam_pkg::GRP_CODE[i], 8'h00, 8'hFF);
            chk(st[15:8], fix(i, k ? 8'h00 : 8'hFF));
            chk(mask[i], fix(i, k ? 8'h00 : 8'hFF));
         end
   endtask
   task t_phase;
      cmd(1'b0, 8'h7A, 8'hFC, 8'h00);
      chk({7'h0, st[pam_pkg::ST_NACK_BIT]}, 8'h01);
      cmd(1'b1, 8'h7A, 8'h00, 8'hFF);
      chk(st[15:8], 8'h00);
   endtask
   task t_alert;
      alrt(1'b0);
      status[1] <= 8'h10;
      alrt(1'b0);
      status[2] <= 8'h01;
      alrt(1'b0);
      status[3] <= 8'h80;
      alrt(1'b1);
      bus(1'b0, pam_pkg::REG_STATUS, 32'h0);
      chk({7'h0, st[pam_pkg::ST_ALERT_BIT]}, 8'h01);
      cmd(1'b0, 8'h7D, 8'h80, 8'hFF);
      alrt(1'b0);
      chk(st_view[3], 8'h80);
   endtask

   task conclude;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // main sequence
   initial
   begin
      rst_n  = 1'b0;
      addr   = 4'h0;
      rd     = 1'b0;
      wr     = 1'b0;
      wdata  = 32'h0;
      status = '0;
      nvm    = {5{8'hA5}};
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_load();
      t_rw();
      t_phase();
      t_alert();
      conclude();
   end
endmodule // tb_pmbus_alert_mask_bank
